/* File: inc/rlhi_pkg.sv */
// rlhi_pkg: shared constants and types for the router link header intake.
// assumes both link ends and the testbench import it whole.
package rlhi_pkg;
   // ----------------------------------------------------------------
   // link sizing
   // ----------------------------------------------------------------
   localparam int unsigned NUM_LINKS       = 32;   // link ports per router
   localparam int unsigned BYTE_W          = 8;    // width of one token data byte
   localparam int unsigned HDR_W           = 16;   // width of the assembled header value
   localparam int unsigned MAX_BODY_BYTES  = 32;   // endpoint payload limit per packet
   localparam int unsigned BODY_CNT_W      = 6;    // counter wide enough for MAX_BODY_BYTES
   localparam int unsigned LINK_IDX_W      = 5;    // output link number width

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned HDR_LO_LSB      = 0;    // first header byte position
   localparam int unsigned HDR_HI_LSB      = 8;    // second header byte position
   localparam logic        HDR_SIZE_RST    = 1'b0; // one-byte headers after reset
   localparam logic [15:0] HDR_RST         = 16'h0000;

   // token kinds carried on the link
   typedef enum logic [1:0] {
      RLHI_TOK_DATA = 2'b00,
      RLHI_TOK_EOP  = 2'b01,
      RLHI_TOK_EOM  = 2'b10
   } rlhi_tok_e;

   // intake state per link
   typedef enum logic [1:0] {
      RLHI_ST_HDR0 = 2'b00,
      RLHI_ST_HDR1 = 2'b01,
      RLHI_ST_BODY = 2'b10,
      RLHI_ST_DROP = 2'b11
   } rlhi_state_e;

   // sender state
   typedef enum logic [1:0] {
      RLHI_TX_IDLE = 2'b00,
      RLHI_TX_HDR  = 2'b01,
      RLHI_TX_BODY = 2'b10,
      RLHI_TX_TERM = 2'b11
   } rlhi_tx_e;
endpackage

/* File: inc/rlhi_link_if.sv */
// rlhi_link_if: token stream between a sending endpoint and one router link.
// assumes one shared clock; valid/ready handshake per token.
`timescale 1ns/100ps
interface rlhi_link_if;
   import rlhi_pkg::*;
   logic            tok_valid;   // sender offers a token
   logic            tok_ready;   // router takes the token
   rlhi_tok_e       tok_kind;    // data, eop or eom
   logic [7:0]      tok_data;    // byte for data tokens

   modport sender (output tok_valid, output tok_kind, output tok_data, input tok_ready);
   modport router (input tok_valid, input tok_kind, input tok_data, output tok_ready);
endinterface

/* File: src/rlhi_router_intake.sv */
// rlhi_router_intake: header intake for all link ports of the router.
// assumes each link is fed by an rlhi_link_if sender end on core_clk,
// and that routing logic consumes the header and body strobes.
// each port gathers a one- or two-byte header,
// strobes it once for the routing decision,
// then passes body tokens until the terminator;
// a two-byte header cut short is flagged and dropped.
// limitation: per_link_packet_config is read live,
// so change it only between packets.
// limitation: one body slot per port; a stalled
// output backs up onto the link at once,
// which is cheaper than a buffer per port.
//
// Functional notes
// R01 - output link chosen from header only
// R02 - all bytes after header are body
// R03 - one eop or eom ends each packet
// R04 - per link one or two byte headers
// R05 - two bytes: first low, second high
// R06 - one byte: low byte, upper zero
// R07 - short two-byte header: error and discard
// R08 - sender body at most 32 bytes
// R09 - sender fills all but final packet; sender sends body_len bytes clipped to 32, also when it closes with eop
// R10 - sender waits for acknowledge per packet
// R11 - acknowledge is header then eop
// R12 - acknowledges routed like any packet
// R13 - headers hold destination only
// R14 - thirty-two link ports, intake per port
// R15 - each packet handled independently
// R16 - body streamed through without storing
// R17 - header strobe after configured byte count
`timescale 1ns/100ps
module rlhi_router_intake
   import rlhi_pkg::*;
(
   input  wire logic                          core_clk,          // system clock, 40 MHz
   input  wire logic                          rst,               // synchronous reset, active high
   rlhi_link_if.router                        link [NUM_LINKS],  // one token stream per port
   input  wire logic [NUM_LINKS-1:0]          per_link_packet_config, // header_size_select per link: 1 = two bytes
   input  wire logic [NUM_LINKS-1:0]          route_ready,       // routing logic takes the presented body token
   output logic      [NUM_LINKS-1:0]          hdr_valid,         // header value valid, one-cycle pulse
   output logic      [NUM_LINKS*HDR_W-1:0]    hdr_value,         // assembled 16-bit header per link
   output logic      [NUM_LINKS-1:0]          body_valid,        // body token presented downstream
   output logic      [NUM_LINKS*BYTE_W-1:0]   body_data,         // body byte per link
   output logic      [NUM_LINKS*2-1:0]        body_kind,         // token kind of presented body token
   output logic      [NUM_LINKS-1:0]          hdr_error          // short header seen, one-cycle pulse
);
   // ----------------------------------------------------------------
   // per-link intake, one copy per port
   // ----------------------------------------------------------------
   // ports share no state, so one link
   // never waits on another
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINKS; gi++) begin : g_link // [R14]
         // header group: state, value, strobes
         rlhi_state_e  st_reg,   st_next;
         logic [15:0]  hdr_reg,  hdr_next;
         logic         hv_reg,   hv_next;
         logic         err_reg,  err_next;

         // body group: one-token output slot
         logic         bv_reg,   bv_next;
         logic [7:0]   bd_reg,   bd_next;
         rlhi_tok_e    bk_reg,   bk_next;

         // decode of the token on offer
         logic         two_byte;
         logic         in_body;
         logic         take;
         logic         body_take;
         logic         is_term;
         logic [7:0]   tok_byte;

         // --------------------------------------------
         // link handshake
         // --------------------------------------------
         // header bytes are never refused;
         // a body token needs the slot free,
         // and route_ready frees it the same cycle,
         // so a flowing stream moves a token per clock
         assign two_byte  = per_link_packet_config[gi];
         assign tok_byte  = link[gi].tok_data;
         assign is_term   = (link[gi].tok_kind != RLHI_TOK_DATA);
         assign in_body   = (st_reg == RLHI_ST_BODY);
         assign link[gi].tok_ready = ~in_body | ~bv_reg | route_ready[gi]; // [R16]
         assign take      = link[gi].tok_valid & link[gi].tok_ready;
         assign body_take = take & in_body;

         // --------------------------------------------
         // header assembly
         // --------------------------------------------
         // only the header value reaches the
         // routing decision; it holds until
         // the next header arrives
         always_comb begin
            st_next  = st_reg;
            hdr_next = hdr_reg;
            hv_next  = 1'b0; // strobes last one cycle
            err_next = 1'b0;
            // nothing moves unless a token is taken
            if (take) begin
               unique case (st_reg)
                  RLHI_ST_HDR0: begin
                     // waiting for the first header byte
                     if (is_term) begin
                        st_next = RLHI_ST_HDR0; // stray terminator before any header is ignored
                     end else if (two_byte) begin // [R04]
                        hdr_next = {8'h00, tok_byte}; // [R05] low byte first
                        st_next  = RLHI_ST_HDR1;
                     end else begin
                        hdr_next = {8'h00, tok_byte}; // [R06]
                        hv_next  = 1'b1;              // [R17] [R01]
                        st_next  = RLHI_ST_BODY;
                     end
                  end

                  RLHI_ST_HDR1: begin
                     // waiting for the second header byte
                     if (is_term) begin
                        // header cut short: flag, no strobe, packet dropped [R07]
                        err_next = 1'b1;
                        st_next  = RLHI_ST_HDR0;
                     end else begin
                        hdr_next[HDR_HI_LSB +: BYTE_W] = tok_byte; // [R05]
                        hv_next  = 1'b1;                           // [R17] [R01]
                        st_next  = RLHI_ST_BODY;
                     end
                  end

                  RLHI_ST_BODY: begin
                     // only a terminator changes state here
                     if (is_term) begin
                        st_next = RLHI_ST_HDR0; // [R03] [R15] next token opens a new packet
                     end
                  end

                  RLHI_ST_DROP: begin
                     // never entered; recovers at the next terminator
                     if (is_term) begin
                        st_next = RLHI_ST_HDR0;
                     end
                  end
               endcase
            end
         end

         // header group registers
         always_ff @(posedge core_clk) begin
            if (rst) begin
               st_reg  <= RLHI_ST_HDR0;
               hdr_reg <= HDR_RST;
               hv_reg  <= 1'b0;
               err_reg <= 1'b0;
            end else begin
               st_reg  <= st_next;
               hdr_reg <= hdr_next;
               hv_reg  <= hv_next;
               err_reg <= err_next;
            end
         end

         // --------------------------------------------
         // body pass-through
         // --------------------------------------------
         // tokens after the header, terminator too,
         // wait here until route_ready;
         // acks take the same path
         always_comb begin
            bv_next = bv_reg & ~route_ready[gi];
            bd_next = bd_reg;
            bk_next = bk_reg;
            // a new token refills the slot even as it empties
            if (body_take) begin
               bv_next = 1'b1; // [R02] [R12]
               bd_next = tok_byte;
               bk_next = link[gi].tok_kind;
            end
         end

         // body group registers
         always_ff @(posedge core_clk) begin
            if (rst) begin
               bv_reg <= 1'b0;
               bd_reg <= 8'h00;
               bk_reg <= RLHI_TOK_DATA;
            end else begin
               bv_reg <= bv_next;
               bd_reg <= bd_next;
               bk_reg <= bk_next;
            end
         end

         // --------------------------------------------
         // output packing
         // --------------------------------------------
         // header value and strobes, link n at its own slice
         assign hdr_valid[gi]                  = hv_reg;
         assign hdr_value[gi*HDR_W +: HDR_W]   = hdr_reg;
         assign hdr_error[gi]                  = err_reg;

         // body slot
         assign body_valid[gi]                 = bv_reg;
         assign body_data[gi*BYTE_W +: BYTE_W] = bd_reg;
         assign body_kind[gi*2 +: 2]           = bk_reg;
      end
   endgenerate
endmodule

/* File: src/rlhi_link_sender.sv */
// rlhi_link_sender: endpoint end that sends one packet per request.
// assumes the router end holds tok_ready as its own back-pressure.
`timescale 1ns/100ps
module rlhi_link_sender
   import rlhi_pkg::*;
(
   input  wire logic                  core_clk,   // system clock, 40 MHz
   input  wire logic                  rst,        // synchronous reset, active high
   rlhi_link_if.sender                link,       // token stream to the router
   input  wire logic                  send_req,   // start a packet, taken when send_busy low
   input  wire logic                  two_byte,   // header_size_select of the target link
   input  wire logic [15:0]           dest_hdr,   // destination label only [R13]
   input  wire logic [5:0]            body_len,   // data bytes, clipped to the limit
   input  wire logic                  end_msg,    // close with eom instead of eop
   input  wire logic [255:0]          body_bytes, // body bytes, byte 0 first
   input  wire logic                  ack_seen,   // previous packet acknowledged
   output logic                       send_busy   // packet in flight or ack pending
);
   // ----------------------------------------------------------------
   // sender state
   // ----------------------------------------------------------------
   rlhi_tx_e     st_reg,   st_next;
   logic [15:0]  hdr_reg,  hdr_next;
   logic         two_reg,  two_next;
   logic         eom_reg,  eom_next;
   logic [5:0]   len_reg,  len_next;
   logic [5:0]   idx_reg,  idx_next;
   logic [255:0] buf_reg,  buf_next;
   logic         wait_reg, wait_next;
   logic         hi_reg,   hi_next;
   logic         fire;

   assign fire = link.tok_valid & link.tok_ready;

   // token presented from current state; data output held in registers above
   always_comb begin
      link.tok_valid = (st_reg != RLHI_TX_IDLE);
      link.tok_kind  = RLHI_TOK_DATA;
      link.tok_data  = 8'h00;
      unique case (st_reg)
         RLHI_TX_IDLE: link.tok_valid = 1'b0;
         RLHI_TX_HDR:  link.tok_data  = hi_reg ? hdr_reg[15:8] : hdr_reg[7:0]; // low byte first [R05]
         RLHI_TX_BODY: link.tok_data  = buf_reg[idx_reg[4:0]*8 +: 8];
         RLHI_TX_TERM: link.tok_kind  = eom_reg ? RLHI_TOK_EOM : RLHI_TOK_EOP; // one terminator [R03]
      endcase
   end

   assign send_busy = (st_reg != RLHI_TX_IDLE) | wait_reg;

   // next-state logic
   always_comb begin
      st_next   = st_reg;
      hdr_next  = hdr_reg;
      two_next  = two_reg;
      eom_next  = eom_reg;
      len_next  = len_reg;
      idx_next  = idx_reg;
      buf_next  = buf_reg;
      hi_next   = hi_reg;
      wait_next = wait_reg & ~ack_seen; // [R10] hold off until acknowledged
      unique case (st_reg)
         RLHI_TX_IDLE: begin
            if (send_req && !wait_reg) begin
               hdr_next = two_byte ? dest_hdr : {8'h00, dest_hdr[7:0]};
               two_next = two_byte;
               eom_next = end_msg;
               len_next = (body_len > 6'(MAX_BODY_BYTES)) ? 6'(MAX_BODY_BYTES) : body_len; // [R08]
               buf_next = body_bytes;
               idx_next = 6'h00;
               hi_next  = 1'b0;
               st_next  = RLHI_TX_HDR;
            end
         end
         RLHI_TX_HDR: begin
            if (fire) begin
               if (two_reg && !hi_reg) begin
                  hi_next = 1'b1;
               end else begin
                  // zero length gives a bare acknowledge packet [R11]
                  st_next = (len_reg == 6'h00) ? RLHI_TX_TERM : RLHI_TX_BODY;
               end
            end
         end
         RLHI_TX_BODY: begin
            if (fire) begin
               idx_next = idx_reg + 6'h01;
               if (idx_reg + 6'h01 == len_reg) begin
                  st_next = RLHI_TX_TERM;
               end
            end
         end
         RLHI_TX_TERM: begin
            if (fire) begin
               // data packets wait for their ack; a zero-length packet is itself an ack [R10] [R09]
               wait_next = (len_reg != 6'h00);
               st_next   = RLHI_TX_IDLE;
            end
         end
      endcase
   end

   // registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg   <= RLHI_TX_IDLE;
         hdr_reg  <= HDR_RST;
         two_reg  <= HDR_SIZE_RST;
         eom_reg  <= 1'b0;
         len_reg  <= 6'h00;
         idx_reg  <= 6'h00;
         buf_reg  <= '0;
         wait_reg <= 1'b0;
         hi_reg   <= 1'b0;
      end else begin
         st_reg   <= st_next;
         hdr_reg  <= hdr_next;
         two_reg  <= two_next;
         eom_reg  <= eom_next;
         len_reg  <= len_next;
         idx_reg  <= idx_next;
         buf_reg  <= buf_next;
         wait_reg <= wait_next;
         hi_reg   <= hi_next;
      end
   end
endmodule

/* File: tb/rlhi_intake_props.sv */
// rlhi_intake_props: protocol checks on link 0 of the router intake.
// assumes link 0 is fed by the sender end and both share core_clk.
`timescale 1ns/100ps
module rlhi_intake_props
   import rlhi_pkg::*;
(
   input wire logic                         core_clk,               // clock
   input wire logic                         rst,                    // sync reset
   input wire logic                         tok_valid,              // offer
   input wire logic                         tok_ready,              // accept
   input wire logic [1:0]                   tok_kind,               // kind
   input wire logic [7:0]                   tok_data,               // byte
   input wire logic [NUM_LINKS-1:0]         per_link_packet_config, // sizes
   input wire logic [NUM_LINKS-1:0]         route_ready,            // take
   input wire logic [NUM_LINKS-1:0]         hdr_valid,              // strobe
   input wire logic [NUM_LINKS*HDR_W-1:0]   hdr_value,              // header
   input wire logic [NUM_LINKS-1:0]         body_valid,             // strobe
   input wire logic [NUM_LINKS*BYTE_W-1:0]  body_data,              // bytes
   input wire logic [NUM_LINKS*2-1:0]       body_kind,              // kinds
   input wire logic [NUM_LINKS-1:0]         hdr_error               // short
);
   // ------------------------------------------------
   // shadow of the link 0 intake state
   // ------------------------------------------------
   rlhi_state_e st_reg, st_next;
   logic [7:0]  lo_reg, lo_next;
   logic [5:0]  bc_reg, bc_next;
   logic        tk;
   logic        dat;
   assign tk  = tok_valid & tok_ready;
   assign dat = tok_kind == RLHI_TOK_DATA;
   // a terminator before any header byte leaves the shadow in header
   always_comb begin
      st_next = st_reg;
      lo_next = lo_reg;
      bc_next = bc_reg;
      if (tk && st_reg == RLHI_ST_HDR0 && dat) begin
         lo_next = tok_data;
         bc_next = 6'h00;
         st_next = per_link_packet_config[0] ? RLHI_ST_HDR1 : RLHI_ST_BODY;
      end else if (tk && st_reg == RLHI_ST_HDR1) begin
         st_next = dat ? RLHI_ST_BODY : RLHI_ST_HDR0;
      end else if (tk && st_reg == RLHI_ST_BODY) begin
         bc_next = bc_reg + {5'h00, dat};
         st_next = dat ? RLHI_ST_BODY : RLHI_ST_HDR0;
      end
   end
   // register only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg <= RLHI_ST_HDR0;
         lo_reg <= 8'h00;
         bc_reg <= 6'h00;
      end else begin
         st_reg <= st_next;
         lo_reg <= lo_next;
         bc_reg <= bc_next;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_hdr_one;
      tk && st_reg == RLHI_ST_HDR0 && dat && !per_link_packet_config[0]
      |=> hdr_valid[0] && hdr_value[15:0] == {8'h00, $past(tok_data)};
   endproperty
   a_hdr_one: assert property (p_hdr_one) else $error("one-byte header value wrong");
   property p_hdr_two;
      tk && st_reg == RLHI_ST_HDR1 && dat |=> hdr_valid[0] && hdr_value[15:0] == {$past(tok_data), $past(lo_reg)};
   endproperty
   a_hdr_two: assert property (p_hdr_two) else $error("two-byte header value wrong");
   property p_hdr_cause;
      hdr_valid[0] |-> $past(tk && dat && (st_reg == RLHI_ST_HDR1 || (st_reg == RLHI_ST_HDR0 && !per_link_packet_config[0])));
   endproperty
   a_hdr_cause: assert property (p_hdr_cause) else $error("header strobe too early");
   property p_short;
      tk && st_reg == RLHI_ST_HDR1 && !dat |=> hdr_error[0] && !hdr_valid[0];
   endproperty
   a_short: assert property (p_short) else $error("short header not flagged");
   property p_err_cause;
      hdr_error[0] |-> $past(tk && st_reg == RLHI_ST_HDR1 && !dat);
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("spurious header error");
   property p_body;
      tk && st_reg == RLHI_ST_BODY |=> body_valid[0] && body_kind[1:0] == $past(tok_kind)
         && (!$past(dat) || body_data[7:0] == $past(tok_data));
   endproperty
   a_body: assert property (p_body) else $error("body token not forwarded");
   property p_stall;
      body_valid[0] && !route_ready[0] |=> body_valid[0] && $stable(body_data[7:0]) && $stable(body_kind[1:0]);
   endproperty
   a_stall: assert property (p_stall) else $error("body token lost under stall");
   property p_ready;
      tok_valid && !tok_ready |-> st_reg == RLHI_ST_BODY && body_valid[0] && !route_ready[0];
   endproperty
   a_ready: assert property (p_ready) else $error("link refused without stall");
   property p_len;
      tk && st_reg == RLHI_ST_BODY && !dat |-> bc_reg <= 6'h20;
   endproperty
   a_len: assert property (p_len) else $error("body longer than limit");
endmodule

/* File: tb/rlhi_router_link_header_intake_bench.sv */
// rlhi_router_link_header_intake_bench: sender on link 0, bench driver on link 1.
// assumes the package and link interface are compiled first.
`timescale 1ns/100ps
module rlhi_router_link_header_intake_bench;
   import rlhi_pkg::*;
   logic core_clk, rst, send_req, two_byte, end_msg, ack_seen, send_busy;
   logic [15:0] dest_hdr, hv_got, hv1_got;
   logic [5:0] body_len;
   logic [255:0] body_bytes;
   logic [NUM_LINKS-1:0] per_link_packet_config, route_ready, hdr_valid, body_valid, hdr_error;
   logic [NUM_LINKS*HDR_W-1:0] hdr_value;
   logic [NUM_LINKS*BYTE_W-1:0] body_data;
   logic [NUM_LINKS*2-1:0] body_kind;
   int n_mismatch, comparisons, hv_cnt, hv1_cnt, err1_cnt, err0_cnt, hv_mark;
   logic [9:0] got_q[$];
   rlhi_link_if lk [NUM_LINKS] ();
   // idle links stay quiet; only 0 and 1 carry traffic
   for (genvar g = 2; g < NUM_LINKS; g++) begin : g_idle
      assign lk[g].tok_valid = 1'b0;
      assign lk[g].tok_kind = RLHI_TOK_DATA;
      assign lk[g].tok_data = 8'h00;
   end
   rlhi_router_intake i_rlhi_router_intake (.core_clk(core_clk), .rst(rst), .link(lk),
      .per_link_packet_config(per_link_packet_config), .route_ready(route_ready), .hdr_valid(hdr_valid),
      .hdr_value(hdr_value), .body_valid(body_valid), .body_data(body_data), .body_kind(body_kind),
      .hdr_error(hdr_error));
   rlhi_link_sender i_rlhi_link_sender (.core_clk(core_clk), .rst(rst), .link(lk[0]), .send_req(send_req),
      .two_byte(two_byte), .dest_hdr(dest_hdr), .body_len(body_len), .end_msg(end_msg),
      .body_bytes(body_bytes), .ack_seen(ack_seen), .send_busy(send_busy));
   rlhi_intake_props i_rlhi_intake_props (.core_clk(core_clk), .rst(rst), .tok_valid(lk[0].tok_valid),
      .tok_ready(lk[0].tok_ready), .tok_kind(lk[0].tok_kind), .tok_data(lk[0].tok_data),
      .per_link_packet_config(per_link_packet_config), .route_ready(route_ready), .hdr_valid(hdr_valid),
      .hdr_value(hdr_value), .body_valid(body_valid), .body_data(body_data), .body_kind(body_kind),
      .hdr_error(hdr_error));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // capture strobes as sampled at the edge
   always @(posedge core_clk) begin
      if (hdr_valid[0]) begin hv_cnt++; hv_got = hdr_value[15:0]; end
      if (hdr_valid[1]) begin hv1_cnt++; hv1_got = hdr_value[31:16]; end
      if (hdr_error[1]) err1_cnt++;
      if (hdr_error[0]) err0_cnt++;
      if (body_valid[0] && route_ready[0]) got_q.push_back({body_kind[1:0], body_data[7:0]});
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one packet from the sender; stall holds route_ready low for a while
   task automatic send_pkt(input logic two, input logic [15:0] dest, input logic [5:0] len,
                           input logic eom, input logic stall);
      int n;
      int hv0;
      logic [5:0] eff;
      eff = (len > 6'h20) ? 6'h20 : len;
      hv0 = hv_cnt;
      n = 0;
      got_q.delete();
      per_link_packet_config[0] <= two;
      two_byte <= two;
      dest_hdr <= dest;
      body_len <= len;
      end_msg <= eom;
      route_ready[0] <= !stall;
      send_req <= 1'b1;
      @(posedge core_clk);
      send_req <= 1'b0;
      while (got_q.size() < int'(eff) + 1 && n < 400) begin
         @(posedge core_clk);
         n++;
         if (n == 12) route_ready[0] <= 1'b1;
      end
      check(16'(hv_cnt - hv0), 16'h0001);
      check(hv_got, two ? dest : {8'h00, dest[7:0]});
      check(16'(got_q.size()), 16'(eff) + 16'h0001);
      for (int i = 0; i < int'(eff); i++) check({6'h00, got_q[i]}, {8'h00, body_bytes[i*8+:8]});
      check({14'h0000, got_q[eff][9:8]}, eom ? 16'h0002 : 16'h0001);
      repeat (3) @(posedge core_clk);
      check({15'h0000, send_busy}, (eff != 6'h00) ? 16'h0001 : 16'h0000);
      ack_seen <= 1'b1;
      @(posedge core_clk);
      ack_seen <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({15'h0000, send_busy}, 16'h0000);
   endtask
   // bench stands in for a faulty sender on link 1; holds each token until taken
   task automatic drv1(input rlhi_tok_e k, input logic [7:0] d);
      int n;
      n = 0;
      lk[1].tok_valid <= 1'b1;
      lk[1].tok_kind <= k;
      lk[1].tok_data <= d;
      do begin @(posedge core_clk); n++; end while (lk[1].tok_ready !== 1'b1 && n < 50);
   endtask
   task automatic link1_seq();
      per_link_packet_config[1] <= 1'b1;
      drv1(RLHI_TOK_EOP, 8'hFF);
      drv1(RLHI_TOK_DATA, 8'h3C);
      drv1(RLHI_TOK_EOM, 8'h00);
      drv1(RLHI_TOK_DATA, 8'h34);
      drv1(RLHI_TOK_DATA, 8'h12);
      drv1(RLHI_TOK_EOP, 8'h00);
      lk[1].tok_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
      check(16'(err1_cnt), 16'h0001);
      check(16'(hv1_cnt), 16'h0001);
      check(hv1_got, 16'h1234);
   endtask
   // watchdog: whole run needs well under 20000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      {rst, send_req, two_byte, end_msg, ack_seen} = 5'h10;
      dest_hdr = 16'h0000;
      body_len = 6'h00;
      per_link_packet_config = '0;
      route_ready = '1;
      {n_mismatch, comparisons, hv_cnt, hv1_cnt, err1_cnt, err0_cnt, hv_mark} = '0;
      lk[1].tok_valid = 1'b0;
      lk[1].tok_kind = RLHI_TOK_DATA;
      lk[1].tok_data = 8'h00;
      for (int i = 0; i < 32; i++) body_bytes[i*8+:8] = 8'(i) ^ 8'hA5;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      send_pkt(1'b0, 16'hA55A, 6'h03, 1'b0, 1'b0);
      send_pkt(1'b1, 16'hA55A, 6'h20, 1'b1, 1'b1);
      send_pkt(1'b1, 16'h00C3, 6'h00, 1'b0, 1'b0);
      send_pkt(1'b0, 16'h12FF, 6'h28, 1'b1, 1'b0);
      // sender gives one header byte, link 0 expects two: cut short
      got_q.delete();
      hv_mark = hv_cnt;
      per_link_packet_config[0] <= 1'b1;
      two_byte <= 1'b0;
      dest_hdr <= 16'h00AA;
      body_len <= 6'h00;
      end_msg <= 1'b0;
      send_req <= 1'b1;
      @(posedge core_clk);
      send_req <= 1'b0;
      repeat (8) @(posedge core_clk);
      check(16'(err0_cnt), 16'h0001);
      check(16'(hv_cnt - hv_mark), 16'h0000);
      check(16'(got_q.size()), 16'h0000);
      fork
         send_pkt(1'b1, 16'hBEEF, 6'h05, 1'b0, 1'b0);
         link1_seq();
      join
      tally_and_finish();
   end
endmodule
